//--- core/dps_map.vh
// Constants of the drive protection supervisor: register map, field
// positions, action codes and timing. Definitions only.
// Operation
// - Analogue input below its minimum raises the input fault.
// - Analogue action: 0 none, 1 alarm one bit 9, 2 trip fault one bit 15.
// - Keypad loss: warn alarm one bit 15; fault in local only, bit 11.
// - External fault: warning runs on; fault trips, fault two bit 6.
// - Input phase loss: 0 silent; 1 trips and sets fault one bit 8.
// - Output phase: 0 none, 1 alarm one bit 4, 2 trip fault two bit 0.
// - Earth fault after summed current stays over threshold for delay.
// - Earth fault: 0 none; 1 trips and sets fault one bit 4.
// - Stall: current high, frequency low, both longer than stall time.
// - Stall action: 0 none, 1 alarm one bit 0, 2 trip fault one bit 3.
// - Thermistor: 0 none, 1 alarm one bit 1, 2 trip fault one bit 7.
// - Encoder loss in closed loop, if acted on, sets fault two bit 2.
// - Encoder sub code: 1 A, 2 B, 3 both, 4 reversed, 5 card missing.
// - Brake supervision only when ack select is 1 to 8.
// - Brake release on run; in closed loop only after 70 percent flux.
// - No ack within lift delay: warn alarm one bit 14, fault two bit 10.
// - No watchdog edge past timeout: follower trips, fault one bit 13.
// - Only followers supervise the watchdog; masters never raise it.
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// Register byte offsets
`define DPS_OFF_CTRL 12'h000
`define DPS_OFF_ACT 12'h004
`define DPS_OFF_AIN_MIN 12'h008
`define DPS_OFF_EARTH_LVL 12'h00c
`define DPS_OFF_EARTH_DLY 12'h010
`define DPS_OFF_STALL_CUR 12'h014
`define DPS_OFF_STALL_FRQ 12'h018
`define DPS_OFF_STALL_TIME 12'h01c
`define DPS_OFF_BRAKE_DLY 12'h020
`define DPS_OFF_FOLLOW_TMO 12'h024
`define DPS_OFF_FAULT1 12'h028
`define DPS_OFF_FAULT2 12'h02c
`define DPS_OFF_ALARM1 12'h030
`define DPS_OFF_STATUS 12'h034

// Control register fields
`define DPS_CTRL_SRC_LSB 0
`define DPS_CTRL_FOLLOWER 2
`define DPS_CTRL_CLOSED 3
`define DPS_CTRL_ACKSEL_LSB 4
`define DPS_CTRL_FRESET 8

// Action register: two bits per condition
`define DPS_ACT_AIN 0
`define DPS_ACT_PANEL 2
`define DPS_ACT_EXT 4
`define DPS_ACT_INPH 6
`define DPS_ACT_OUTPH 8
`define DPS_ACT_EARTH 10
`define DPS_ACT_STALL 12
`define DPS_ACT_THERM 14
`define DPS_ACT_ENC 16
`define DPS_ACT_BRAKE 18

`define DPS_ACTION_NONE 2'h0
`define DPS_ACTION_WARN 2'h1
`define DPS_ACTION_FAULT 2'h2
`define DPS_SRC_LOCAL 2'h2

// Word bit positions
`define DPS_A1_STALL 0
`define DPS_A1_THERM 1
`define DPS_A1_OUTPH 4
`define DPS_A1_AIN 9
`define DPS_A1_BRAKE 14
`define DPS_A1_PANEL 15
`define DPS_F1_STALL 3
`define DPS_F1_EARTH 4
`define DPS_F1_THERM 7
`define DPS_F1_INPH 8
`define DPS_F1_PANEL 11
`define DPS_F1_FOLLOW 13
`define DPS_F1_AIN 15
`define DPS_F2_OUTPH 0
`define DPS_F2_ENC 2
`define DPS_F2_EXT 6
`define DPS_F2_BRAKE 10

// Reset values
`define DPS_RST_CTRL 32'h0000_0000
`define DPS_RST_ACT 32'h0000_0000
`define DPS_RST_LEVEL 16'h0000
`define DPS_RST_TIME 16'h0064
`define DPS_RST_FOLLOW 16'h07d0

// Timing: one supervision tick per millisecond
`define DPS_TICK_MS 1
`define DPS_CLK_KHZ 200000
`define DPS_TICK_CYC (`DPS_TICK_MS * `DPS_CLK_KHZ)
`define DPS_FLUX_PCT 70

`endif

//--- core/dps_supervisor.v
// Drive protection supervisor with APB register access.
// Assumes conditions come from drive logic on sys_clk, except the digital
// inputs and the master watchdog which are pins.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dps_map.vh"
module dps_supervisor #(
  parameter TICK_CYC = `DPS_TICK_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurements and conditions from the drive
  input wire [15:0] ain_level,
  input wire [15:0] earth_current,
  input wire [15:0] motor_current,
  input wire [15:0] output_freq,
  input wire [7:0] flux_pct,
  input wire panel_lost,
  input wire ext_fault,
  input wire in_phase_lost,
  input wire out_phase_lost,
  input wire therm_hot,
  input wire [2:0] enc_sub_code,
  input wire run_req,
  // Pins
  input wire [3:0] digital_input_pins,
  input wire master_watchdog,
  // Results
  output reg trip_q,
  output reg brake_release_q,
  output reg [15:0] fault_word_one_q,
  output reg [15:0] fault_word_two_q,
  output reg [15:0] alarm_word_one_q,
  output reg [2:0] enc_sub_q
);
  reg [31:0] ctrl_q;
  reg [31:0] act_q;
  reg [15:0] ain_min_q;
  reg [15:0] earth_lvl_q;
  reg [15:0] earth_dly_q;
  reg [15:0] stall_cur_q;
  reg [15:0] stall_frq_q;
  reg [15:0] stall_time_q;
  reg [15:0] brake_dly_q;
  reg [15:0] follow_tmo_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg [2:0] wd_sync_q;
  reg wd_last_q;
  wire [3:0] din_q;
  reg fault_reset_q;

  // Action field decode used for every condition except the follower watchdog
  function [1:0] act_of;
    input [31:0] a;
    input integer lsb;
    begin
      act_of = a[lsb +: 2];
    end
  endfunction

  wire [1:0] control_source_select = ctrl_q[`DPS_CTRL_SRC_LSB +: 2];
  wire follower = ctrl_q[`DPS_CTRL_FOLLOWER];
  wire closed_loop = ctrl_q[`DPS_CTRL_CLOSED];
  wire [3:0] brake_ack_input_select = ctrl_q[`DPS_CTRL_ACKSEL_LSB +: 4];

  // APB
  wire wr = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire known = (paddr[1:0] == 2'h0) && (paddr <= `DPS_OFF_STATUS);

  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `DPS_RST_CTRL;
      act_q <= `DPS_RST_ACT;
      ain_min_q <= `DPS_RST_LEVEL;
      earth_lvl_q <= `DPS_RST_LEVEL;
      earth_dly_q <= `DPS_RST_TIME;
      stall_cur_q <= `DPS_RST_LEVEL;
      stall_frq_q <= `DPS_RST_LEVEL;
      stall_time_q <= `DPS_RST_TIME;
      brake_dly_q <= `DPS_RST_TIME;
      follow_tmo_q <= `DPS_RST_FOLLOW;
      fault_reset_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      // Zero-wait answer: pready rises in the access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      fault_reset_q <= 1'b0;
      if (wr && known)
      begin
        case (paddr)
          `DPS_OFF_CTRL:
          begin
            ctrl_q <= pwdata & 32'h0000_00ff;
            fault_reset_q <= pwdata[`DPS_CTRL_FRESET];
          end
          `DPS_OFF_ACT: act_q <= pwdata & 32'h000f_ffff;
          `DPS_OFF_AIN_MIN: ain_min_q <= pwdata[15:0];
          `DPS_OFF_EARTH_LVL: earth_lvl_q <= pwdata[15:0];
          `DPS_OFF_EARTH_DLY: earth_dly_q <= pwdata[15:0];
          `DPS_OFF_STALL_CUR: stall_cur_q <= pwdata[15:0];
          `DPS_OFF_STALL_FRQ: stall_frq_q <= pwdata[15:0];
          `DPS_OFF_STALL_TIME: stall_time_q <= pwdata[15:0];
          `DPS_OFF_BRAKE_DLY: brake_dly_q <= pwdata[15:0];
          `DPS_OFF_FOLLOW_TMO: follow_tmo_q <= pwdata[15:0];
          default: ;
        endcase
      end
      if (rd_setup)
      begin
        case (paddr)
          `DPS_OFF_CTRL: prdata <= ctrl_q;
          `DPS_OFF_ACT: prdata <= act_q;
          `DPS_OFF_AIN_MIN: prdata <= {16'h0000, ain_min_q};
          `DPS_OFF_EARTH_LVL: prdata <= {16'h0000, earth_lvl_q};
          `DPS_OFF_EARTH_DLY: prdata <= {16'h0000, earth_dly_q};
          `DPS_OFF_STALL_CUR: prdata <= {16'h0000, stall_cur_q};
          `DPS_OFF_STALL_FRQ: prdata <= {16'h0000, stall_frq_q};
          `DPS_OFF_STALL_TIME: prdata <= {16'h0000, stall_time_q};
          `DPS_OFF_BRAKE_DLY: prdata <= {16'h0000, brake_dly_q};
          `DPS_OFF_FOLLOW_TMO: prdata <= {16'h0000, follow_tmo_q};
          `DPS_OFF_FAULT1: prdata <= {16'h0000, fault_word_one_q};
          `DPS_OFF_FAULT2: prdata <= {16'h0000, fault_word_two_q};
          `DPS_OFF_ALARM1: prdata <= {16'h0000, alarm_word_one_q};
          `DPS_OFF_STATUS:
            prdata <= {25'h0000000, enc_sub_q, brake_release_q,
                       wd_last_q, din_q[0], trip_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Millisecond tick
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q >= TICK_CYC - 1)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // Pin synchronisers; a change counts when stages two and three agree
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wd_sync_q <= 3'h0;
      wd_last_q <= 1'b0;
    end
    else
    begin
      wd_sync_q <= {wd_sync_q[1:0], master_watchdog};
      if (wd_sync_q[1] == wd_sync_q[2])
        wd_last_q <= wd_sync_q[2];
    end
  end

  // One chain per input pin; bit order follows the pin bus
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_din
      reg [2:0] sync_q;
      reg level_q;
      always @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          sync_q <= 3'h0;
          level_q <= 1'b0;
        end
        else
        begin
          sync_q <= {sync_q[1:0], digital_input_pins[gi]};
          // Glitches shorter than a cycle never reach the level
          if (sync_q[1] == sync_q[2])
            level_q <= sync_q[2];
        end
      end
      assign din_q[gi] = level_q;
    end
  endgenerate

  wire wd_edge = (wd_sync_q[1] == wd_sync_q[2]) &&
                 (wd_sync_q[2] != wd_last_q);

  // Brake acknowledge: 1..4 plain, 5..8 inverted input
  wire brake_sup = (brake_ack_input_select != 4'h0) &&
                   (brake_ack_input_select <= 4'h8);
  wire [1:0] ack_idx = brake_ack_input_select[1:0] - 2'h1;
  wire ack_inv = brake_ack_input_select > 4'h4;
  wire brake_ack = din_q[ack_idx] ^ ack_inv;

  // Persistence timers
  wire earth_exp;
  wire stall_exp;
  wire brake_exp;
  wire follow_exp;
  wire earth_cond = earth_current > earth_lvl_q;
  wire stall_cond = (motor_current > stall_cur_q) &&
                    (output_freq < stall_frq_q);
  wire brake_cond = brake_sup && brake_release_q && !brake_ack;
  wire follow_cond = follower;

  dps_timer #(.W(16)) u_earth (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick_q),
    .cond(earth_cond), .restart(1'b0), .limit(earth_dly_q),
    .expired_q(earth_exp)
  );
  dps_timer #(.W(16)) u_stall (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick_q),
    .cond(stall_cond), .restart(1'b0), .limit(stall_time_q),
    .expired_q(stall_exp)
  );
  dps_timer #(.W(16)) u_brake (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick_q),
    .cond(brake_cond), .restart(1'b0), .limit(brake_dly_q),
    .expired_q(brake_exp)
  );
  dps_timer #(.W(16)) u_follow (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick_q),
    .cond(follow_cond), .restart(wd_edge), .limit(follow_tmo_q),
    .expired_q(follow_exp)
  );

  // Conditions and actions
  wire ain_low = ain_level < ain_min_q;
  wire enc_bad = closed_loop && (enc_sub_code != 3'h0);
  wire [1:0] a_ain = act_of(act_q, `DPS_ACT_AIN);
  wire [1:0] a_pan = act_of(act_q, `DPS_ACT_PANEL);
  wire [1:0] a_ext = act_of(act_q, `DPS_ACT_EXT);
  wire [1:0] a_inp = act_of(act_q, `DPS_ACT_INPH);
  wire [1:0] a_out = act_of(act_q, `DPS_ACT_OUTPH);
  wire [1:0] a_ear = act_of(act_q, `DPS_ACT_EARTH);
  wire [1:0] a_stl = act_of(act_q, `DPS_ACT_STALL);
  wire [1:0] a_thm = act_of(act_q, `DPS_ACT_THERM);
  wire [1:0] a_enc = act_of(act_q, `DPS_ACT_ENC);
  wire [1:0] a_brk = act_of(act_q, `DPS_ACT_BRAKE);

  reg [15:0] alarm_d;
  reg [15:0] f1_set;
  reg [15:0] f2_set;
  always @*
  begin
    alarm_d = 16'h0000;
    f1_set = 16'h0000;
    f2_set = 16'h0000;
    alarm_d[`DPS_A1_AIN] = ain_low && a_ain == `DPS_ACTION_WARN;
    f1_set[`DPS_F1_AIN] = ain_low && a_ain == `DPS_ACTION_FAULT;
    alarm_d[`DPS_A1_PANEL] = panel_lost && a_pan == `DPS_ACTION_WARN;
    f1_set[`DPS_F1_PANEL] = panel_lost && a_pan == `DPS_ACTION_FAULT &&
      control_source_select == `DPS_SRC_LOCAL;
    f2_set[`DPS_F2_EXT] = ext_fault && a_ext == `DPS_ACTION_FAULT;
    // Input phase uses 1 as its fault code
    f1_set[`DPS_F1_INPH] = in_phase_lost && a_inp == 2'h1;
    alarm_d[`DPS_A1_OUTPH] = out_phase_lost && a_out == `DPS_ACTION_WARN;
    f2_set[`DPS_F2_OUTPH] = out_phase_lost &&
      a_out == `DPS_ACTION_FAULT;
    f1_set[`DPS_F1_EARTH] = earth_exp && a_ear == 2'h1;
    alarm_d[`DPS_A1_STALL] = stall_exp && a_stl == `DPS_ACTION_WARN;
    f1_set[`DPS_F1_STALL] = stall_exp &&
      a_stl == `DPS_ACTION_FAULT;
    alarm_d[`DPS_A1_THERM] = therm_hot && a_thm == `DPS_ACTION_WARN;
    f1_set[`DPS_F1_THERM] = therm_hot &&
      a_thm == `DPS_ACTION_FAULT;
    // Encoder warning marks fault word two but never trips
    f2_set[`DPS_F2_ENC] = enc_bad &&
      a_enc == `DPS_ACTION_FAULT;
    alarm_d[`DPS_A1_BRAKE] = brake_exp && a_brk == `DPS_ACTION_WARN;
    f2_set[`DPS_F2_BRAKE] = brake_exp &&
      a_brk == `DPS_ACTION_FAULT;
    f1_set[`DPS_F1_FOLLOW] = follow_exp;
  end

  wire enc_warn = enc_bad && a_enc == `DPS_ACTION_WARN;

  // Latched trips; a new cause wins over the fault reset
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      fault_word_one_q <= 16'h0000;
      fault_word_two_q <= 16'h0000;
      alarm_word_one_q <= 16'h0000;
      trip_q <= 1'b0;
      enc_sub_q <= 3'h0;
      brake_release_q <= 1'b0;
    end
    else
    begin
      alarm_word_one_q <= alarm_d;
      if (fault_reset_q)
      begin
        fault_word_one_q <= f1_set;
        fault_word_two_q <= f2_set | {13'h0000, enc_warn, 2'h0};
        trip_q <= |{f1_set, f2_set};
      end
      else
      begin
        fault_word_one_q <= fault_word_one_q | f1_set;
        fault_word_two_q <= fault_word_two_q | f2_set |
          {13'h0000, enc_warn, 2'h0};
        trip_q <= trip_q | (|{f1_set, f2_set});
      end
      if (enc_bad && a_enc != `DPS_ACTION_NONE)
        enc_sub_q <= enc_sub_code;
      else if (fault_reset_q)
        enc_sub_q <= 3'h0;
      // Tripping drops the brake
      brake_release_q <= run_req && !trip_q &&
        (!closed_loop || flux_pct >= `DPS_FLUX_PCT);
    end
  end
endmodule
`default_nettype wire

//--- core/dps_timer.v
// Persistence timer: counts ticks while its condition holds.
// Assumes a one-cycle tick enable on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dps_timer #(
  parameter W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Control
  input wire tick,
  input wire cond,
  input wire restart,
  input wire [W-1:0] limit,
  // Result
  output reg expired_q
);
  reg [W-1:0] cnt_q;
  always @(posedge sys_clk)
  begin
    if (!rst_b || !cond || restart)
    begin
      cnt_q <= {W{1'b0}};
      expired_q <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt_q >= limit)
        expired_q <= 1'b1;
      else
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

//--- dv/dps_master_model.sv
// Master drive watchdog source for a follower.
// Assumes the bench starts and stops it; half period in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module dps_master_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bench control
  input wire logic run,
  input wire logic [7:0] half,
  // Watchdog pin
  output logic master_watchdog
);
  logic [7:0] cnt_q;
  // Square wave, scaled: a second is far too long to simulate
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= 8'h00;
      master_watchdog <= 1'b0;
    end
    else if (run)
    begin
      cnt_q <= (cnt_q + 8'h01 >= half) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q + 8'h01 >= half)
        master_watchdog <= ~master_watchdog;
    end
  end
endmodule
`default_nettype wire

//--- dv/dps_supervisor_sva.sv
// Port checker for the protection supervisor.
// Assumes bind to dps_supervisor; config is shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
module dps_supervisor_sva (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Conditions
  input wire panel_lost,
  input wire ext_fault,
  input wire in_phase_lost,
  input wire out_phase_lost,
  input wire therm_hot,
  input wire [2:0] enc_sub_code,
  input wire run_req,
  // Results
  input wire trip_q,
  input wire brake_release_q,
  input wire [15:0] fault_word_one_q,
  input wire [15:0] fault_word_two_q,
  input wire [15:0] alarm_word_one_q,
  input wire [2:0] enc_sub_q
);
  reg [8:0] ctrl_q;
  reg [19:0] act_q;
  wire wr = psel & penable & pready & pwrite;
  wire fr = wr & (paddr == 12'h000) & pwdata[8];
  wire is_local = ctrl_q[1:0] == 2'h2;
  wire [31:0] fw = {fault_word_two_q, fault_word_one_q};
  // Shadow updates at the same edge the slave takes the write
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ctrl_q <= 9'h000;
      act_q <= 20'h00000;
    end
    else if (wr && paddr == 12'h000)
      ctrl_q <= pwdata[8:0];
    else if (wr && paddr == 12'h004)
      act_q <= pwdata[19:0];
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  property p_panel;
    act_q[3:2] == 2'h2 && is_local && panel_lost
      |=> fault_word_one_q[11] && trip_q;
  endproperty
  a_panel: assert property (p_panel)
    else $error("panel trip missing");
  property p_remote;
    $rose(fault_word_one_q[11]) |-> $past(is_local);
  endproperty
  a_remote: assert property (p_remote)
    else $error("panel fault outside local");
  property p_ext;
    act_q[5:4] == 2'h2 && ext_fault |=> fault_word_two_q[6] && trip_q;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external trip missing");
  property p_inph;
    act_q[7:6] == 2'h1 && in_phase_lost |=> fault_word_one_q[8] && trip_q;
  endproperty
  a_inph: assert property (p_inph)
    else $error("input phase trip missing");
  property p_outph;
    act_q[9:8] == 2'h1 && out_phase_lost |=> alarm_word_one_q[4];
  endproperty
  a_outph: assert property (p_outph)
    else $error("output phase alarm missing");
  property p_therm;
    act_q[15:14] == 2'h1 && therm_hot && !fault_word_one_q[7]
      |=> alarm_word_one_q[1] && !fault_word_one_q[7];
  endproperty
  a_therm: assert property (p_therm)
    else $error("thermistor alarm wrong");
  property p_warn_follow;
    !therm_hot |=> !alarm_word_one_q[1];
  endproperty
  a_warn_follow: assert property (p_warn_follow)
    else $error("thermistor alarm stuck");
  property p_enc;
    act_q[17:16] != 2'h0 && ctrl_q[3] && enc_sub_code != 3'h0
      && enc_sub_code <= 3'h5
      |=> fault_word_two_q[2] && enc_sub_q == $past(enc_sub_code);
  endproperty
  a_enc: assert property (p_enc)
    else $error("encoder indication wrong");
  property p_follow;
    $rose(fault_word_one_q[13]) |-> $past(ctrl_q[2]);
  endproperty
  a_follow: assert property (p_follow)
    else $error("watchdog fault in master");
  property p_brake;
    !run_req |=> !brake_release_q;
  endproperty
  a_brake: assert property (p_brake)
    else $error("brake released without run");
  property p_latch;
    !fr && !$past(fr) |=> (fw & $past(fw)) == $past(fw);
  endproperty
  a_latch: assert property (p_latch)
    else $error("fault bit dropped without reset");
  c_trip: cover property ($rose(trip_q));
  c_follow: cover property ($rose(fault_word_one_q[13]));
  c_brake: cover property ($rose(brake_release_q));
endmodule
`default_nettype wire

//--- dv/tb_drive_protection_supervisor.sv
// Testbench for the protection supervisor: table of actions, then timed cases.
// Assumes TICK_CYC of 4 so timers run in a few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_protection_supervisor;
  typedef struct packed {
    logic [19:0] act;
    logic [8:0] ctl;
    logic [5:0] fl;
    logic [2:0] enc;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [15:0] a1;
    logic trip;
  } dps_row_t;
  localparam logic [15:0] NOM_CUR = 16'h0640;
  logic sys_clk, rst_b, psel, penable, pwrite, panel_lost, ext_fault;
  logic in_phase_lost, out_phase_lost, therm_hot, run_req, wd_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] ain_level, earth_current, motor_current, output_freq;
  logic [7:0] flux_pct;
  logic [2:0] enc_sub_code;
  logic [3:0] digital_input_pins;
  wire master_watchdog, pready, pslverr, trip_q, brake_release_q;
  wire [31:0] prdata;
  wire [15:0] fault_word_one_q, fault_word_two_q, alarm_word_one_q;
  wire [2:0] enc_sub_q;
  int n_fail, checks;
  logic er;
  dps_row_t r;
  dps_row_t rows [15] = '{
    '{20'h00001,9'h000,6'h20,3'h0,16'h0000,16'h0000,16'h0200,1'b0},
    '{20'h00002,9'h000,6'h20,3'h0,16'h8000,16'h0000,16'h0000,1'b1},
    '{20'h00004,9'h000,6'h10,3'h0,16'h0000,16'h0000,16'h8000,1'b0},
    '{20'h00008,9'h002,6'h10,3'h0,16'h0800,16'h0000,16'h0000,1'b1},
    '{20'h00008,9'h001,6'h10,3'h0,16'h0000,16'h0000,16'h0000,1'b0},
    '{20'h00010,9'h000,6'h08,3'h0,16'h0000,16'h0000,16'h0000,1'b0},
    '{20'h00020,9'h000,6'h08,3'h0,16'h0000,16'h0040,16'h0000,1'b1},
    '{20'h00000,9'h000,6'h04,3'h0,16'h0000,16'h0000,16'h0000,1'b0},
    '{20'h00040,9'h000,6'h04,3'h0,16'h0100,16'h0000,16'h0000,1'b1},
    '{20'h00100,9'h000,6'h02,3'h0,16'h0000,16'h0000,16'h0010,1'b0},
    '{20'h00200,9'h000,6'h02,3'h0,16'h0000,16'h0001,16'h0000,1'b1},
    '{20'h04000,9'h000,6'h01,3'h0,16'h0000,16'h0000,16'h0002,1'b0},
    '{20'h08000,9'h000,6'h01,3'h0,16'h0080,16'h0000,16'h0000,1'b1},
    '{20'h10000,9'h008,6'h00,3'h1,16'h0000,16'h0004,16'h0000,1'b0},
    '{20'h20000,9'h008,6'h00,3'h5,16'h0000,16'h0004,16'h0000,1'b1}};
  dps_supervisor #(.TICK_CYC(4)) dut (.sys_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ain_level,
    .earth_current, .motor_current, .output_freq, .flux_pct, .panel_lost,
    .ext_fault, .in_phase_lost, .out_phase_lost, .therm_hot, .enc_sub_code,
    .run_req, .digital_input_pins, .master_watchdog, .trip_q,
    .brake_release_q, .fault_word_one_q, .fault_word_two_q,
    .alarm_word_one_q, .enc_sub_q);
  dps_master_model u_mst (.sys_clk, .rst_b, .run(wd_run), .half(8'h14),
    .master_watchdog);
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task finish_test;
  begin
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
  begin
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task rsd;
  begin
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
  end
  endtask
  // Waits on pready; no fixed latency assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
  begin
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20)
    begin
      n_fail++;
      finish_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task drv(input logic [5:0] f, input logic [2:0] e);
  begin
    ain_level <= f[5] ? 16'h0010 : 16'h0200;
    panel_lost <= f[4];
    ext_fault <= f[3];
    in_phase_lost <= f[2];
    out_phase_lost <= f[1];
    therm_hot <= f[0];
    enc_sub_code <= e;
  end
  endtask
  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, wd_run, run_req} = '0;
    {earth_current, motor_current, output_freq, flux_pct} = '0;
    {digital_input_pins, ain_level, enc_sub_code} = '0;
    {panel_lost, ext_fault, in_phase_lost, out_phase_lost, therm_hot} = '0;
    wt(3);
    rst_b <= 1'b1;
    apb(1'b0, 12'h024, 32'h0);
    chk("tmo_reset", 16'h07d0, rd[15:0]);
    chk("trip_reset", 16'h0000, {15'h0, trip_q});
    foreach (rows[i])
    begin
      r = rows[i];
      rsd;
      apb(1'b1, 12'h008, 32'h0000_0100);
      apb(1'b1, 12'h000, {23'h0, r.ctl});
      apb(1'b1, 12'h004, {12'h0, r.act});
      drv(r.fl, r.enc);
      wt(3);
      chk("f1", r.f1, fault_word_one_q);
      chk("f2", r.f2, fault_word_two_q);
      chk("a1", r.a1, alarm_word_one_q);
      chk("trip", {15'h0, r.trip}, {15'h0, trip_q});
      chk("enc", {13'h0, r.enc}, {13'h0, enc_sub_q});
      drv(6'h00, 3'h0);
      wt(3);
      chk("a1_clr", 16'h0000, alarm_word_one_q);
      chk("f1_held", r.f1, fault_word_one_q);
      chk("trip_held", {15'h0, r.trip}, {15'h0, trip_q});
    end
    for (int c = 1; c <= 5; c++)
    begin
      enc_sub_code <= c[2:0];
      wt(3);
      chk("enc_code", c[15:0], {13'h0, enc_sub_q});
    end
    enc_sub_code <= 3'h0;
    apb(1'b0, 12'h02c, 32'h0);
    chk("f2_read", 16'h0004, rd[15:0]);
    apb(1'b1, 12'h000, 32'h0000_0108);
    wt(3);
    chk("f2_rst", 16'h0000, fault_word_two_q);
    chk("trip_rst", 16'h0000, {15'h0, trip_q});
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr", 16'h0001, {15'h0, er});
    rsd;
    apb(1'b1, 12'h00c, {16'h0, NOM_CUR / 16'h0014});
    apb(1'b1, 12'h010, 32'h0000_0005);
    apb(1'b1, 12'h014, 32'h0000_0080);
    apb(1'b1, 12'h018, 32'h0000_0020);
    apb(1'b1, 12'h01c, 32'h0000_0003);
    apb(1'b1, 12'h004, 32'h0000_1400);
    earth_current <= 16'h0060;
    motor_current <= 16'h0090;
    output_freq <= 16'h0030;
    wt(8);
    earth_current <= 16'h0000;
    wt(40);
    chk("earth_short", 16'h0000, fault_word_one_q);
    chk("stall_freq", 16'h0000, alarm_word_one_q);
    earth_current <= 16'h0060;
    output_freq <= 16'h0010;
    wt(40);
    chk("earth", 16'h0010, fault_word_one_q);
    chk("stall", 16'h0001, alarm_word_one_q);
    apb(1'b1, 12'h004, 32'h0000_2400);
    wt(3);
    chk("stall_trip", 16'h0018, fault_word_one_q);
    rsd;
    apb(1'b1, 12'h020, 32'h0000_0004);
    apb(1'b1, 12'h004, 32'h0004_0000);
    apb(1'b1, 12'h000, 32'h0000_0008);
    flux_pct <= 8'h32;
    run_req <= 1'b1;
    wt(3);
    chk("brk_flux", 16'h0000, {15'h0, brake_release_q});
    flux_pct <= 8'h46;
    wt(40);
    chk("brk_rel", 16'h0001, {15'h0, brake_release_q});
    chk("brk_off", 16'h0000, alarm_word_one_q);
    run_req <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0018);
    run_req <= 1'b1;
    wt(40);
    chk("brk_alarm", 16'h4000, alarm_word_one_q);
    apb(1'b1, 12'h004, 32'h0008_0000);
    wt(3);
    chk("brk_fault", 16'h0400, fault_word_two_q);
    apb(1'b1, 12'h000, 32'h0000_0158);
    wt(40);
    chk("brk_inv", 16'h0000, fault_word_two_q);
    rsd;
    apb(1'b1, 12'h024, 32'h0000_000a);
    wt(100);
    chk("wd_master", 16'h0000, fault_word_one_q);
    apb(1'b1, 12'h000, 32'h0000_0004);
    wd_run <= 1'b1;
    wt(100);
    chk("wd_alive", 16'h0000, fault_word_one_q);
    wd_run <= 1'b0;
    wt(80);
    chk("wd_lost", 16'h2000, fault_word_one_q);
    finish_test;
  end
endmodule
bind dps_supervisor dps_supervisor_sva u_sva (.sys_clk, .rst_b, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .panel_lost, .ext_fault,
  .in_phase_lost, .out_phase_lost, .therm_hot, .enc_sub_code, .run_req,
  .trip_q, .brake_release_q, .fault_word_one_q, .fault_word_two_q,
  .alarm_word_one_q, .enc_sub_q);
`default_nettype wire
